// >>> verilog/obs_sequencer.sv
// host sequencer that burns and verifies the sensor's fuse registers
// assumes the sensor's power rail is switched by pwr_en_q and the link
// is the sensor's spi slave; one start runs the whole sequence
`timescale 1ns/1ps
// Operation
// - after power-up write both custom config words before any burn
// - factory bit 0 of custom_config_a is always written as zero
// - angle bits 5:0 go to zero_offset_low, bits 13:6 to zero_offset_high
// - read back the four fuse registers 0x0016 to 0x0019 before burning
// - every readback comparison ignores bit 0 of custom_config_a
// - set fuse_access_enable only after the first readback matched
// - after access is enabled, start the burn with fuse_burn_start
// - poll the programming control register until it reads 0x0000
// - after the burn write 0x00 to every fuse register location
// - enable access again, then set guard_band_select to 1
// - setting fuse_reload makes the device reload from the fuses
// - guard-banded mismatch marks the part bad; never program it again
// - after a passing guard check power-cycle and compare a third time
// - guard band used only in this sequence, within one hour of burn
module obs_sequencer #(
  parameter int unsigned PWR_OFF_CYC = int'(obs_pkg::PWR_OFF_CYC),
  parameter int unsigned PWR_UP_CYC  = int'(obs_pkg::PWR_UP_CYC),
  parameter int unsigned POLL_TO_CYC = int'(obs_pkg::POLL_TO_CYC),
  parameter logic [39:0] GUARD_CYC   = 40'(obs_pkg::GUARD_CYC)
) (
  // system
  input  wire logic       clock,
  input  wire logic       nrst,
  // user orders
  input  wire logic       start,
  input  wire logic [7:0] cfg_a,
  input  wire logic [7:0] cfg_b,
  // user status
  output logic            busy_q,
  output logic            done_q,
  output logic            pass_q,
  output obs_pkg::obs_fail_t fail_code_q,
  output logic            locked_q,
  output logic [13:0]     zero_offset_q,
  // sensor power and link
  output logic            pwr_en_q,
  output logic            spi_sclk,
  output logic            spi_csn,
  output logic            spi_mosi,
  input  wire logic       spi_miso
);

  typedef enum logic [2:0] {
    S_IDLE    = 3'b000,
    S_PWR_OFF = 3'b001,
    S_PWR_UP  = 3'b010,
    S_ISSUE   = 3'b011,
    S_CMD     = 3'b100,
    S_DATA    = 3'b101,
    S_EVAL    = 3'b110
  } obs_state_t;

  obs_state_t          state_q;
  logic [4:0]          step_q;
  logic [7:0]          ca_q;
  logic [7:0]          cb_q;
  logic [31:0]         cnt_q;
  logic [39:0]         guard_q;
  logic                guard_on_q;
  logic [15:0]         rx_q;
  obs_pkg::obs_frame_t frame_q;
  logic                spi_done;
  logic [15:0]         spi_rx;

  // frame with even parity over the whole word
  function automatic logic [15:0] frame_of(input logic rw,
                                           input logic [13:0] v);
    frame_of = {^{rw, v}, rw, v};
  endfunction : frame_of

  // a single one in bit b of a 14-bit register word
  function automatic logic [13:0] bit_word(input int b);
    bit_word = 14'h0001 << b;
  endfunction : bit_word

  // value the fuse register at addr must hold
  function automatic logic [7:0] expect_of(input logic [13:0] addr,
                                           input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic [13:0] z);
    logic [7:0] r;
    r = 8'h00;
    if (addr == obs_pkg::ADDR_ZHIGH) begin
      r = z[obs_pkg::ANG_MSB:obs_pkg::ZHIGH_LSB];
    end else if (addr == obs_pkg::ADDR_ZLOW) begin
      r = {2'b00, z[obs_pkg::ZLOW_MSB:0]};
    end else if (addr == obs_pkg::ADDR_CFG_A) begin
      r = a;
    end else if (addr == obs_pkg::ADDR_CFG_B) begin
      r = b;
    end
    expect_of = r;
  endfunction : expect_of

  // the sequence as a table of steps
  function automatic obs_pkg::obs_step_t step_of(input logic [4:0] s,
                                                 input logic [7:0] a,
                                                 input logic [7:0] b,
                                                 input logic [13:0] z);
    obs_pkg::obs_step_t r;
    logic [1:0]         off;
    r = '{kind: obs_pkg::K_END, addr: obs_pkg::ADDR_NOP,
          data: 14'h0000, chk: 1'b0};
    off = 2'b00;
    if (s == obs_pkg::ST_PWR1 || s == obs_pkg::ST_PWR2) begin
      r.kind = obs_pkg::K_POWER;
    end else if (s == obs_pkg::ST_CFG_A) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_CFG_A;
      r.data = {6'h00, a};
    end else if (s == obs_pkg::ST_CFG_B) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_CFG_B;
      r.data = {6'h00, b};
    end else if (s == obs_pkg::ST_ANGLE) begin
      r.kind = obs_pkg::K_READ;
      r.addr = obs_pkg::ADDR_ANGLE;
    end else if (s == obs_pkg::ST_ZLOW) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_ZLOW;
      r.data = {8'h00, z[obs_pkg::ZLOW_MSB:0]};
    end else if (s == obs_pkg::ST_ZHIGH) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_ZHIGH;
      r.data = {6'h00, z[obs_pkg::ANG_MSB:obs_pkg::ZHIGH_LSB]};
    end else if (s == obs_pkg::ST_EN1 || s == obs_pkg::ST_EN2) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_PROG;
      r.data = bit_word(obs_pkg::BIT_ACCESS);
    end else if (s == obs_pkg::ST_BURN) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_PROG;
      r.data = bit_word(obs_pkg::BIT_BURN);
    end else if (s == obs_pkg::ST_POLL) begin
      r.kind = obs_pkg::K_READ;
      r.addr = obs_pkg::ADDR_PROG;
    end else if (s == obs_pkg::ST_GUARD) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_PROG;
      r.data = bit_word(obs_pkg::BIT_GUARD);
    end else if (s == obs_pkg::ST_RELOAD) begin
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_PROG;
      r.data = bit_word(obs_pkg::BIT_RELOAD);
    end else if (s >= obs_pkg::ST_CLR && s < obs_pkg::ST_EN2) begin
      off    = 2'(s - obs_pkg::ST_CLR);
      r.kind = obs_pkg::K_WRITE;
      r.addr = obs_pkg::ADDR_NV_FIRST + {12'h000, off};
      r.data = {6'h00, obs_pkg::NV_CLEAR};
    end else if (s >= obs_pkg::ST_RB1 && s < obs_pkg::ST_EN1) begin
      off    = 2'(s - obs_pkg::ST_RB1);
      r.kind = obs_pkg::K_READ;
      r.addr = obs_pkg::ADDR_NV_FIRST + {12'h000, off};
      r.chk  = 1'b1;
    end else if (s >= obs_pkg::ST_RB2 && s < obs_pkg::ST_PWR2) begin
      off    = 2'(s - obs_pkg::ST_RB2);
      r.kind = obs_pkg::K_READ;
      r.addr = obs_pkg::ADDR_NV_FIRST + {12'h000, off};
      r.chk  = 1'b1;
    end else if (s >= obs_pkg::ST_RB3 && s < obs_pkg::ST_END) begin
      off    = 2'(s - obs_pkg::ST_RB3);
      r.kind = obs_pkg::K_READ;
      r.addr = obs_pkg::ADDR_NV_FIRST + {12'h000, off};
      r.chk  = 1'b1;
    end
    step_of = r;
  endfunction : step_of

  // decoding of the current step and its outcome
  obs_pkg::obs_step_t cur;
  assign cur = step_of(step_q, ca_q, cb_q, zero_offset_q);

  wire [7:0] exp_v  = expect_of(cur.addr, ca_q, cb_q, zero_offset_q);
  wire [7:0] got_m  = (cur.addr == obs_pkg::ADDR_CFG_A) ?
                      (rx_q[7:0] & ~8'h01) : rx_q[7:0];
  wire [7:0] exp_m  = (cur.addr == obs_pkg::ADDR_CFG_A) ?
                      (exp_v & ~8'h01) : exp_v;
  wire       miss   = cur.chk && (got_m != exp_m);
  wire       is_ang = (step_q == obs_pkg::ST_ANGLE);
  wire       is_pol = (step_q == obs_pkg::ST_POLL);
  wire       burned = (rx_q[13:0] == obs_pkg::PROG_DONE);
  wire       pol_to = (cnt_q >= POLL_TO_CYC);
  wire       win_to = guard_on_q && (guard_q >= GUARD_CYC);
  wire       in_rb2 = (step_q >= obs_pkg::ST_RB2) &&
                      (step_q < obs_pkg::ST_PWR2);
  wire       in_rb3 = (step_q >= obs_pkg::ST_RB3);

  wire obs_pkg::obs_fail_t miss_code =
    in_rb3 ? obs_pkg::F_FINAL :
    in_rb2 ? obs_pkg::F_GUARD : obs_pkg::F_VERIFY1;

  wire [15:0] cmd_word  = frame_of(cur.kind == obs_pkg::K_READ ?
                                   obs_pkg::RW_READ : obs_pkg::RW_WRITE,
                                   cur.addr);
  wire [15:0] tail_word = (cur.kind == obs_pkg::K_READ) ?
                          frame_of(obs_pkg::RW_READ, obs_pkg::ADDR_NOP) :
                          frame_of(obs_pkg::RW_WRITE, cur.data);

  // guard window counter runs from burn start to the end of readback two
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      guard_q <= 40'h00_0000_0000;
    end else if (guard_on_q) begin
      guard_q <= guard_q + 40'h00_0000_0001;
    end else begin
      guard_q <= 40'h00_0000_0000;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q       <= S_IDLE;
      step_q        <= 5'h00;
      ca_q          <= 8'h00;
      cb_q          <= 8'h00;
      cnt_q         <= 32'h0000_0000;
      guard_on_q    <= 1'b0;
      rx_q          <= 16'h0000;
      frame_q       <= '{req: 1'b0, word: 16'h0000};
      busy_q        <= 1'b0;
      done_q        <= 1'b0;
      pass_q        <= 1'b0;
      fail_code_q   <= obs_pkg::F_NONE;
      locked_q      <= 1'b0;
      zero_offset_q <= 14'h0000;
      pwr_en_q      <= 1'b1;
    end else begin
      done_q      <= 1'b0;
      frame_q.req <= 1'b0;
      cnt_q       <= cnt_q + 32'h0000_0001;
      unique case (state_q)
        S_IDLE: if (start && !locked_q) begin
          ca_q        <= cfg_a & ~8'h01;
          cb_q        <= cfg_b;
          step_q      <= obs_pkg::ST_PWR1;
          busy_q      <= 1'b1;
          pass_q      <= 1'b0;
          fail_code_q <= obs_pkg::F_NONE;
          state_q     <= S_ISSUE;
        end
        S_PWR_OFF: if (cnt_q >= PWR_OFF_CYC) begin
          pwr_en_q <= 1'b1;
          cnt_q    <= 32'h0000_0000;
          state_q  <= S_PWR_UP;
        end
        S_PWR_UP: if (cnt_q >= PWR_UP_CYC) begin
          step_q  <= step_q + 5'h01;
          state_q <= S_ISSUE;
        end
        S_ISSUE: begin
          unique case (cur.kind)
            obs_pkg::K_POWER: begin
              pwr_en_q   <= 1'b0;
              guard_on_q <= 1'b0;
              cnt_q      <= 32'h0000_0000;
              state_q    <= S_PWR_OFF;
            end
            obs_pkg::K_END: begin
              pass_q  <= 1'b1;
              done_q  <= 1'b1;
              busy_q  <= 1'b0;
              state_q <= S_IDLE;
            end
            default: begin
              if (step_q == obs_pkg::ST_BURN) begin
                locked_q   <= 1'b1;
                guard_on_q <= 1'b1;
              end
              frame_q <= '{req: 1'b1, word: cmd_word};
              state_q <= S_CMD;
            end
          endcase
        end
        S_CMD: if (spi_done) begin
          frame_q <= '{req: 1'b1, word: tail_word};
          state_q <= S_DATA;
        end
        S_DATA: if (spi_done) begin
          rx_q    <= spi_rx;
          state_q <= S_EVAL;
        end
        S_EVAL: begin
          if (win_to) begin
            fail_code_q <= obs_pkg::F_WINDOW;
            done_q      <= 1'b1;
            busy_q      <= 1'b0;
            state_q     <= S_IDLE;
          end else if (miss) begin
            fail_code_q <= miss_code;
            done_q      <= 1'b1;
            busy_q      <= 1'b0;
            state_q     <= S_IDLE;
          end else if (is_pol && !burned) begin
            if (pol_to) begin
              fail_code_q <= obs_pkg::F_TIMEOUT;
              done_q      <= 1'b1;
              busy_q      <= 1'b0;
              state_q     <= S_IDLE;
            end else begin
              state_q <= S_ISSUE;
            end
          end else begin
            if (is_ang) begin
              zero_offset_q <= rx_q[13:0];
            end
            cnt_q   <= 32'h0000_0000;
            step_q  <= step_q + 5'h01;
            state_q <= S_ISSUE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  obs_spi_master u_spi (
    .clock  (clock),
    .nrst   (nrst),
    .req    (frame_q),
    .done_q (spi_done),
    .rx_q   (spi_rx),
    .sclk_q (spi_sclk),
    .csn_q  (spi_csn),
    .mosi_q (spi_mosi),
    .miso   (spi_miso)
  );

endmodule : obs_sequencer

// >>> verilog/obs_pkg.sv
// constants and types for the fuse burn and verify sequencer
// assumes a sensor slave on a four-wire spi link, mode 1, 16-bit frames
package obs_pkg;

  // clock and link timing
  localparam longint unsigned CLK_HZ      = 64'd25_000_000;
  localparam int              SPI_HALF    = 4;
  localparam int              SPI_GAP     = 8;
  localparam int              SPI_BITS    = 16;

  // times in their own units, counts derived from the clock rate
  localparam longint unsigned PWR_OFF_MS  = 64'd10;
  localparam longint unsigned PWR_UP_MS   = 64'd10;
  localparam longint unsigned POLL_TO_MS  = 64'd100;
  localparam longint unsigned GUARD_WIN_S = 64'd3600;
  localparam longint unsigned PWR_OFF_CYC = (PWR_OFF_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned PWR_UP_CYC  = (PWR_UP_MS * CLK_HZ + 999) / 1000;
  localparam longint unsigned POLL_TO_CYC = (POLL_TO_MS * CLK_HZ) / 1000;
  localparam longint unsigned GUARD_CYC   = GUARD_WIN_S * CLK_HZ;

  // frame layout
  localparam int PAR_BIT = 15;
  localparam int RW_BIT  = 14;
  localparam logic RW_READ  = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  // device register addresses
  localparam logic [13:0] ADDR_NOP      = 14'h0000;
  localparam logic [13:0] ADDR_PROG     = 14'h0003;
  localparam logic [13:0] ADDR_ANGLE    = 14'h3fff;
  localparam logic [13:0] ADDR_NV_FIRST = 14'h0016;
  localparam logic [13:0] ADDR_ZHIGH    = 14'h0016;
  localparam logic [13:0] ADDR_ZLOW     = 14'h0017;
  localparam logic [13:0] ADDR_CFG_A    = 14'h0018;
  localparam logic [13:0] ADDR_CFG_B    = 14'h0019;

  // programming control bits and values
  localparam int          BIT_ACCESS = 0;
  localparam int          BIT_RELOAD = 2;
  localparam int          BIT_BURN   = 3;
  localparam int          BIT_GUARD  = 6;
  localparam logic [13:0] PROG_DONE  = 14'h0000;
  localparam logic [7:0]  NV_CLEAR   = 8'h00;
  localparam int          CFG_FACTORY_BIT = 0;

  // zero offset split of the measured angle
  localparam int ZLOW_MSB  = 5;
  localparam int ZHIGH_LSB = 6;
  localparam int ANG_MSB   = 13;

  // sequence step numbers
  localparam logic [4:0] ST_PWR1   = 5'h00;
  localparam logic [4:0] ST_CFG_A  = 5'h01;
  localparam logic [4:0] ST_CFG_B  = 5'h02;
  localparam logic [4:0] ST_ANGLE  = 5'h03;
  localparam logic [4:0] ST_ZLOW   = 5'h04;
  localparam logic [4:0] ST_ZHIGH  = 5'h05;
  localparam logic [4:0] ST_RB1    = 5'h06;
  localparam logic [4:0] ST_EN1    = 5'h0a;
  localparam logic [4:0] ST_BURN   = 5'h0b;
  localparam logic [4:0] ST_POLL   = 5'h0c;
  localparam logic [4:0] ST_CLR    = 5'h0d;
  localparam logic [4:0] ST_EN2    = 5'h11;
  localparam logic [4:0] ST_GUARD  = 5'h12;
  localparam logic [4:0] ST_RELOAD = 5'h13;
  localparam logic [4:0] ST_RB2    = 5'h14;
  localparam logic [4:0] ST_PWR2   = 5'h18;
  localparam logic [4:0] ST_RB3    = 5'h19;
  localparam logic [4:0] ST_END    = 5'h1d;

  typedef enum logic [1:0] {
    K_WRITE = 2'b00,
    K_READ  = 2'b01,
    K_POWER = 2'b10,
    K_END   = 2'b11
  } obs_kind_t;

  typedef enum logic [2:0] {
    F_NONE    = 3'b000,
    F_VERIFY1 = 3'b001,
    F_TIMEOUT = 3'b010,
    F_GUARD   = 3'b011,
    F_FINAL   = 3'b100,
    F_WINDOW  = 3'b101
  } obs_fail_t;

  typedef struct packed {
    obs_kind_t   kind;
    logic [13:0] addr;
    logic [13:0] data;
    logic        chk;
  } obs_step_t;

  typedef struct packed {
    logic        req;
    logic [15:0] word;
  } obs_frame_t;

endpackage : obs_pkg

// >>> verilog/obs_spi_master.sv
// spi master moving one 16-bit frame per request, mode 1
// assumes a slave that shifts out on rising sclk and samples on falling
`timescale 1ns/1ps
module obs_spi_master (
  // system
  input  wire logic              clock,
  input  wire logic              nrst,
  // frame request and answer
  input  wire obs_pkg::obs_frame_t req,
  output logic                   done_q,
  output logic [15:0]            rx_q,
  // link pins
  output logic                   sclk_q,
  output logic                   csn_q,
  output logic                   mosi_q,
  input  wire logic              miso
);

  typedef enum logic [2:0] {
    SP_IDLE  = 3'b000,
    SP_LEAD  = 3'b001,
    SP_HIGH  = 3'b010,
    SP_LOW   = 3'b011,
    SP_TRAIL = 3'b100,
    SP_GAP   = 3'b101
  } obs_sp_t;

  obs_sp_t     state_q;
  logic [3:0]  cnt_q;
  logic [4:0]  bit_q;
  logic [15:0] sh_q;
  logic        m1_q;
  logic        m2_q;

  wire half_end = (cnt_q == 4'(obs_pkg::SPI_HALF - 1));
  wire gap_end  = (cnt_q == 4'(obs_pkg::SPI_GAP - 1));
  wire last_bit = (bit_q == 5'(obs_pkg::SPI_BITS - 1));

  // miso crosses in through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      m1_q <= 1'b0;
      m2_q <= 1'b0;
    end else begin
      m1_q <= miso;
      m2_q <= m1_q;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_q <= SP_IDLE;
      cnt_q   <= 4'h0;
      bit_q   <= 5'h00;
      sh_q    <= 16'h0000;
      rx_q    <= 16'h0000;
      done_q  <= 1'b0;
      sclk_q  <= 1'b0;
      csn_q   <= 1'b1;
      mosi_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      cnt_q  <= cnt_q + 4'h1;
      unique case (state_q)
        SP_IDLE: begin
          cnt_q <= 4'h0;
          if (req.req) begin
            sh_q    <= req.word;
            csn_q   <= 1'b0;
            state_q <= SP_LEAD;
          end
        end
        SP_LEAD: if (half_end) begin
          sclk_q  <= 1'b1;
          mosi_q  <= sh_q[15];
          sh_q    <= {sh_q[14:0], 1'b0};
          bit_q   <= 5'h00;
          cnt_q   <= 4'h0;
          state_q <= SP_HIGH;
        end
        SP_HIGH: if (half_end) begin
          sclk_q  <= 1'b0;
          cnt_q   <= 4'h0;
          state_q <= SP_LOW;
        end
        SP_LOW: if (half_end) begin
          rx_q  <= {rx_q[14:0], m2_q};
          cnt_q <= 4'h0;
          if (last_bit) begin
            state_q <= SP_TRAIL;
          end else begin
            bit_q   <= bit_q + 5'h01;
            sclk_q  <= 1'b1;
            mosi_q  <= sh_q[15];
            sh_q    <= {sh_q[14:0], 1'b0};
            state_q <= SP_HIGH;
          end
        end
        SP_TRAIL: if (half_end) begin
          csn_q   <= 1'b1;
          mosi_q  <= 1'b0;
          cnt_q   <= 4'h0;
          state_q <= SP_GAP;
        end
        SP_GAP: if (gap_end) begin
          done_q  <= 1'b1;
          state_q <= SP_IDLE;
        end
        default: state_q <= SP_IDLE;
      endcase
    end
  end

endmodule : obs_spi_master

// >>> verif/obs_sequencer_sva.sv
// checker for the fuse burn sequencer status and link ports
// assumes one clock domain and the top module's port names
`timescale 1ns/1ps
module obs_sequencer_chk (
  // system
  input wire logic               clock,
  input wire logic               nrst,
  // user side
  input wire logic               start,
  input wire logic               busy_q,
  input wire logic               done_q,
  input wire logic               pass_q,
  input wire obs_pkg::obs_fail_t fail_code_q,
  input wire logic               locked_q,
  // sensor side
  input wire logic               pwr_en_q,
  input wire logic               spi_csn
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_off; !pwr_en_q [*8]; endsequence
  sequence s_frame; !spi_csn [*8]; endsequence
  property p_start; start && !busy_q && !locked_q && !done_q |=> busy_q;
  endproperty
  property p_done; done_q |-> !busy_q ##1 !done_q; endproperty
  property p_pass; done_q && pass_q |-> fail_code_q == obs_pkg::F_NONE;
  endproperty
  property p_fail; done_q && !pass_q |-> fail_code_q != obs_pkg::F_NONE;
  endproperty
  property p_nolock;
    done_q && fail_code_q == obs_pkg::F_VERIFY1 |-> !locked_q;
  endproperty
  property p_lock; done_q && fail_code_q inside {obs_pkg::F_TIMEOUT,
    obs_pkg::F_GUARD, obs_pkg::F_FINAL, obs_pkg::F_WINDOW} |-> locked_q;
  endproperty
  property p_refuse; locked_q && !busy_q |=> !busy_q; endproperty
  property p_pwr; $fell(pwr_en_q) |-> s_off; endproperty
  property p_frame; $fell(spi_csn) |-> s_frame ##1 !spi_csn; endproperty
  property p_idle; !busy_q |-> spi_csn && pwr_en_q; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  a_done: assert property (p_done) else $error("done not a pulse");
  a_pass: assert property (p_pass) else $error("pass with code");
  a_fail: assert property (p_fail) else $error("fail no code");
  a_nolock: assert property (p_nolock) else $error("burn on bad rb");
  a_lock: assert property (p_lock) else $error("not locked");
  a_refuse: assert property (p_refuse) else $error("restart");
  a_pwr: assert property (p_pwr) else $error("short power off");
  a_frame: assert property (p_frame) else $error("short frame");
  a_idle: assert property (p_idle) else $error("idle pins");
endmodule : obs_sequencer_chk

bind obs_sequencer obs_sequencer_chk chk_i (.clock(clock), .nrst(nrst),
  .start(start), .busy_q(busy_q), .done_q(done_q), .pass_q(pass_q),
  .fail_code_q(fail_code_q), .locked_q(locked_q), .pwr_en_q(pwr_en_q),
  .spi_csn(spi_csn));

// >>> verif/obs_sensor_model.sv
// behavioural sensor slave with fuse registers, spi mode 1
// assumes the bench picks a fault mode per part, 0 is a good part
`timescale 1ns/1ps
module obs_sensor_model (
  // power and link
  input wire logic        pwr_en,
  input wire logic        sclk,
  input wire logic        csn,
  input wire logic        mosi,
  output logic            miso,
  // part behaviour
  input wire logic [2:0]  mode,
  input wire logic [13:0] angle
);
  logic [7:0]  nv[4];
  logic [7:0]  fuse[4];
  logic [15:0] sh;
  logic [15:0] out;
  logic [13:0] wa;
  logic        wpend;
  logic        en;
  int          busyc;
  task fresh;
    for (int i = 0; i < 4; i++) begin
      fuse[i] = 8'h00;
      nv[i] = 8'h00;
    end
  endtask : fresh
  initial begin
    miso = 1'b0;
    fresh();
  end
  always @(negedge sclk) if (!csn) sh <= {sh[14:0], mosi};
  always @(posedge sclk) if (!csn) begin
    miso <= out[15];
    out <= {out[14:0], 1'b0};
  end
  always @(negedge pwr_en) begin
    nv = fuse;
    if (mode == 3'd4) nv[3] = nv[3] ^ 8'h01;
    wpend = 1'b0;
    busyc = 0;
    en = 1'b0;
  end
  always @(posedge csn) if (pwr_en) begin
    miso <= ~miso;
    out = 16'hffff;
    if (wpend) begin
      wpend = 1'b0;
      if (wa == obs_pkg::ADDR_PROG) begin
        if (sh[3] && en) begin
          fuse = nv;
          if (mode == 3'd3) fuse[1] = fuse[1] ^ 8'h02;
          busyc = (mode == 3'd2) ? 1000000 : (mode == 3'd5) ? 19 : 3;
        end
        if (sh[2]) nv = fuse;
        en = sh[0];
      end else if (wa >= 14'h0016 && wa <= 14'h0019) nv[wa-14'h16] = sh[7:0];
    end else if (!sh[14]) begin
      wpend = 1'b1;
      wa = sh[13:0];
    end else if (sh[13:0] == obs_pkg::ADDR_ANGLE) out = {2'b00, angle};
    else if (sh[13:0] == obs_pkg::ADDR_PROG) begin
      out = (busyc > 0) ? 16'h0008 : 16'h0000;
      if (busyc > 0) busyc--;
    end else if (sh[13:0] >= 14'h0016 && sh[13:0] <= 14'h0019) begin
      out = {8'h00, nv[sh[1:0]-2'd2]};
      if (sh[13:0] == 14'h0018) out[0] = 1'b1;
      if (sh[13:0] == 14'h0019 && mode == 3'd1) out[4] = ~out[4];
    end
  end
endmodule : obs_sensor_model

// >>> verif/tb_obs_sequencer.sv
// testbench for the fuse burn and verify sequencer
// assumes obs_pkg, the checker bind and the sensor model are compiled
`timescale 1ns/1ps
module tb_obs_sequencer;
  typedef struct packed {
    logic        pass;
    logic [2:0]  code;
    logic        locked;
    logic [13:0] zo;
  } obs_exp_t;
  logic clock = 1'b0, nrst = 1'b0, start = 1'b0, miso;
  logic [7:0] cfg_a = 8'h00, cfg_b = 8'h00;
  logic [2:0] mode = 3'h0;
  logic [13:0] angle = 14'h0000, zo;
  logic busy, done, pass, locked, pwr, sclk, csn, mosi;
  obs_pkg::obs_fail_t code;
  obs_exp_t q[$];
  int failures = 0, samples_checked = 0;
  obs_sequencer #(.PWR_OFF_CYC(20), .PWR_UP_CYC(20), .POLL_TO_CYC(6000),
    .GUARD_CYC(40'h0000001f40)) obs_sequencer_i (.clock(clock),
    .nrst(nrst), .start(start), .cfg_a(cfg_a), .cfg_b(cfg_b),
    .busy_q(busy), .done_q(done), .pass_q(pass), .fail_code_q(code),
    .locked_q(locked), .zero_offset_q(zo), .pwr_en_q(pwr),
    .spi_sclk(sclk), .spi_csn(csn), .spi_mosi(mosi), .spi_miso(miso));
  obs_sensor_model obs_sensor_model_i (.pwr_en(pwr), .sclk(sclk),
    .csn(csn), .mosi(mosi), .miso(miso), .mode(mode), .angle(angle));
  initial forever #20 clock = ~clock;
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task report_and_stop;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task do_reset;
    nrst = 1'b0;
    repeat (4) @(negedge clock);
    nrst = 1'b1;
  endtask : do_reset
  task run(input logic [2:0] m, input logic [2:0] c);
    obs_exp_t e;
    int n;
    mode = m;
    angle = 14'($urandom);
    cfg_a = 8'($urandom);
    cfg_b = 8'($urandom);
    obs_sensor_model_i.fresh();
    e = '{c == 3'h0, c, c != 3'h1, angle};
    q.push_back(e);
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 40000) failures++;
    if (c == 3'h0) cmp("fuses", {angle[13:6], 2'b00, angle[5:0],
      cfg_a & 8'hfe, cfg_b}, {obs_sensor_model_i.fuse[0],
      obs_sensor_model_i.fuse[1], obs_sensor_model_i.fuse[2],
      obs_sensor_model_i.fuse[3]});
    $display("test mode %0d ended after %0d cycles", m, n);
  endtask : run
  always @(negedge clock) if (done === 1'b1) begin
    if (q.size() == 0) failures++;
    else cmp("status", 32'(q.pop_front()),
      32'({pass, code, locked, zo}));
  end
  initial begin
    #(90000 * 40);
    failures++;
    report_and_stop();
  end
  initial begin
    void'($urandom(70));
    do_reset();
    run(3'h1, obs_pkg::F_VERIFY1);
    run(3'h0, obs_pkg::F_NONE);
    start = 1'b1;
    repeat (6) @(negedge clock);
    cmp("busy refused", 32'h0, 32'(busy));
    $display("test refuse ended");
    start = 1'b0;
    do_reset();
    run(3'h3, obs_pkg::F_GUARD);
    do_reset();
    run(3'h4, obs_pkg::F_FINAL);
    do_reset();
    run(3'h2, obs_pkg::F_TIMEOUT);
    do_reset();
    run(3'h5, obs_pkg::F_WINDOW);
    repeat (4) @(negedge clock);
    report_and_stop();
  end
endmodule : tb_obs_sequencer
